//--- fdc_defines.svh
//
// Function
// - Toggle stage inverts on every count event, half the input rate.
// - BCD bit 0 comes straight from the toggle stage through a buffer.
// - Exactly one of five pair lines is high: 0-1, 2-3, 4-5, 6-7, 8-9.
// - BCD equals count 0..9 and returns to zero at the tenth event.
// - Carry low for counts 0-4, high for 5-9, falls at ten.
// - Unit reset idles high; its falling edge pulses reset and clear.
// - Reset and clear pulses return toggle and ring to zero count.
// - While clear is high the toggle is held with bit 0 low.
// - Shaped count is the inverse of the toggle primary output, opposite to BCD bit 0.
// - All ring stages see the count event; each step flips one stage.
// - Each ring level is plus, zero or minus from stage and predecessor.
// - After reset levels are plus, minus, plus, minus, zero.
// - First count: shaped count low, only stage five flips.
// - Second count: shaped count high, only stage one flips.
// - The stage at zero level flips on each count, arming the next.
// - Ring levels follow a ten-step cycle, back to reset at ten.
// - Pair line high only when adjacent stages read plus and zero.
// - Upper BCD bits are encoded from the pair lines.
// - Carry compares stages four and five; high while four more positive.
//
`ifndef FDC_DEFINES_SVH
`define FDC_DEFINES_SVH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FDC_RING_RESET    5'h1a
`define FDC_TOGGLE_RESET  1'h0
`define FDC_UNIT_IDLE     1'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FDC_PAIR_01       0
`define FDC_PAIR_23       1
`define FDC_PAIR_45       2
`define FDC_PAIR_67       3
`define FDC_PAIR_89       4
`define FDC_STAGE_D       3
`define FDC_STAGE_E       4

`endif

//--- fdc_pkg.sv
package fdc_pkg;

    typedef enum logic [1:0] {
        FDC_LVL_PLUS  = 2'h1,
        FDC_LVL_ZERO  = 2'h0,
        FDC_LVL_MINUS = 2'h2
    } fdc_level_t;

    typedef struct packed {
        logic [3:0] bcd;
        logic       carry;
        logic [4:0] pair;
    } fdc_out_t;

endpackage : fdc_pkg

//--- fdc_reset_pulse.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defines.svh"

module fdc_reset_pulse (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic unit_reset_n,
    output logic      fall,
    output logic      pulse_q
);
    logic unit_prev_q;

    // ------------------------------------------------------------
    // Falling edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            unit_prev_q <= `FDC_UNIT_IDLE;
        end else begin
            unit_prev_q <= unit_reset_n;
        end
    end

    assign fall = unit_prev_q & ~unit_reset_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= 1'h0;
        end else begin
            pulse_q <= fall;
        end
    end

endmodule : fdc_reset_pulse

`default_nettype wire

//--- fdc_first_decade.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defines.svh"

module fdc_first_decade (
    input  wire logic                  CLOCK,
    input  wire logic                  RSTN,
    input  wire logic                  COUNT_EVENT,
    input  wire logic                  COUNTER_UNIT_RESET_N,
    output fdc_pkg::fdc_out_t          DECADE_OUT,
    output fdc_pkg::fdc_level_t [4:0]  RING_LEVEL,
    output logic                       SHAPED_COUNT,
    output logic                       RESET_PULSE,
    output logic                       CLEAR_PULSE
);
    import fdc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic fdc_level_t stage_level(input logic own, input logic prev);
        logic [1:0] units;
        units = {1'b0, own} + {1'b0, ~prev};
        case (units)
            2'h0:    stage_level = FDC_LVL_PLUS;
            2'h1:    stage_level = FDC_LVL_ZERO;
            default: stage_level = FDC_LVL_MINUS;
        endcase
    endfunction : stage_level

    function automatic logic pair_hit(input fdc_level_t a, input fdc_level_t b);
        pair_hit = (a == FDC_LVL_PLUS && b == FDC_LVL_ZERO) ||
                   (a == FDC_LVL_ZERO && b == FDC_LVL_PLUS);
    endfunction : pair_hit

    function automatic logic [1:0] level_rank(input fdc_level_t a);
        case (a)
            FDC_LVL_PLUS: level_rank = 2'h2;
            FDC_LVL_ZERO: level_rank = 2'h1;
            default:      level_rank = 2'h0;
        endcase
    endfunction : level_rank

    function automatic logic more_positive(input fdc_level_t a, input fdc_level_t b);
        more_positive = level_rank(a) > level_rank(b);
    endfunction : more_positive

    function automatic fdc_level_t [4:0] ring_levels(input logic [4:0] ring);
        ring_levels[0] = stage_level(ring[0], ring[4]);
        for (int i = 1; i < 5; i++) begin
            ring_levels[i] = stage_level(ring[i], ring[i-1]);
        end
    endfunction : ring_levels

    // ------------------------------------------------------------
    // Reset pulse generator
    // ------------------------------------------------------------
    logic clr_fall;
    logic clr_pulse_q;
    logic clr_any;

    fdc_reset_pulse u_reset_pulse (
        .clock        (CLOCK),
        .rst_n        (RSTN),
        .unit_reset_n (COUNTER_UNIT_RESET_N),
        .fall         (clr_fall),
        .pulse_q      (clr_pulse_q)
    );

    assign clr_any     = clr_fall | clr_pulse_q;
    assign RESET_PULSE = clr_pulse_q;
    assign CLEAR_PULSE = clr_pulse_q;

    // ------------------------------------------------------------
    // Toggle stage
    // ------------------------------------------------------------
    logic toggle_q;
    logic toggle_d;

    always_comb begin
        if (clr_any) begin
            toggle_d = `FDC_TOGGLE_RESET;
        end else begin
            toggle_d = toggle_q ^ COUNT_EVENT;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            toggle_q <= `FDC_TOGGLE_RESET;
        end else begin
            toggle_q <= toggle_d;
        end
    end

    // ------------------------------------------------------------
    // Ring counter
    // ------------------------------------------------------------
    localparam logic [4:0] RING_RST = `FDC_RING_RESET;

    logic [4:0]       ring_q;
    logic [4:0]       ring_d;
    logic             stage_a_q;
    logic             stage_b_q;
    logic             stage_c_q;
    logic             stage_d_q;
    logic             stage_e_q;

    assign ring_q = {stage_e_q, stage_d_q, stage_c_q, stage_b_q, stage_a_q};
    fdc_level_t [4:0] lvl_q;
    fdc_level_t [4:0] lvl_d;

    assign lvl_q = ring_levels(ring_q);

    always_comb begin
        ring_d = ring_q;
        if (clr_any) begin
            ring_d = `FDC_RING_RESET;
        end else if (COUNT_EVENT) begin
            for (int i = 0; i < 5; i++) begin
                ring_d[i] = ring_q[i] ^ (lvl_q[i] == FDC_LVL_ZERO);
            end
        end
    end

    // ------------------------------------------------------------
    // Ring stage A
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            stage_a_q <= RING_RST[0];
        end else begin
            stage_a_q <= ring_d[0];
        end
    end

    // ------------------------------------------------------------
    // Ring stage B
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            stage_b_q <= RING_RST[1];
        end else begin
            stage_b_q <= ring_d[1];
        end
    end

    // ------------------------------------------------------------
    // Ring stage C
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            stage_c_q <= RING_RST[2];
        end else begin
            stage_c_q <= ring_d[2];
        end
    end

    // ------------------------------------------------------------
    // Ring stage D
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            stage_d_q <= RING_RST[3];
        end else begin
            stage_d_q <= ring_d[3];
        end
    end

    // ------------------------------------------------------------
    // Ring stage E
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            stage_e_q <= RING_RST[4];
        end else begin
            stage_e_q <= ring_d[4];
        end
    end

    assign lvl_d = ring_levels(ring_d);

    // ------------------------------------------------------------
    // Pair lines
    // ------------------------------------------------------------
    logic [4:0] pair_d;
    logic [3:0] bcd_d;
    logic       carry_d;
    logic [4:0] pair_q;
    logic [3:0] bcd_q;
    logic       carry_q;

    always_comb begin
        pair_d = '0;
        pair_d[`FDC_PAIR_01] = pair_hit(lvl_d[4], lvl_d[0]);
        pair_d[`FDC_PAIR_23] = pair_hit(lvl_d[1], lvl_d[2]);
        pair_d[`FDC_PAIR_45] = pair_hit(lvl_d[3], lvl_d[4]);
        pair_d[`FDC_PAIR_67] = pair_hit(lvl_d[0], lvl_d[1]);
        pair_d[`FDC_PAIR_89] = pair_hit(lvl_d[2], lvl_d[3]);
    end

    // ------------------------------------------------------------
    // BCD encoder
    // ------------------------------------------------------------
    always_comb begin
        bcd_d    = '0;
        bcd_d[0] = toggle_d;
        bcd_d[1] = pair_d[`FDC_PAIR_23] | pair_d[`FDC_PAIR_67];
        bcd_d[2] = pair_d[`FDC_PAIR_45] | pair_d[`FDC_PAIR_67];
        bcd_d[3] = pair_d[`FDC_PAIR_89];
    end

    // ------------------------------------------------------------
    // Carry comparator
    // ------------------------------------------------------------
    always_comb begin
        carry_d = more_positive(lvl_d[`FDC_STAGE_D], lvl_d[`FDC_STAGE_E]);
    end

    // ------------------------------------------------------------
    // Count register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            bcd_q <= 4'h0;
        end else begin
            bcd_q <= bcd_d;
        end
    end

    // ------------------------------------------------------------
    // Carry register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            carry_q <= 1'h0;
        end else begin
            carry_q <= carry_d;
        end
    end

    // ------------------------------------------------------------
    // Pair register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pair_q <= 5'h01;
        end else begin
            pair_q <= pair_d;
        end
    end

    assign DECADE_OUT = '{bcd: bcd_q, carry: carry_q, pair: pair_q};

    // ------------------------------------------------------------
    // Ring level register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            RING_LEVEL <= '{FDC_LVL_ZERO, FDC_LVL_MINUS, FDC_LVL_PLUS,
                            FDC_LVL_MINUS, FDC_LVL_PLUS};
        end else begin
            RING_LEVEL <= lvl_d;
        end
    end

    // ------------------------------------------------------------
    // Shaped count register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            SHAPED_COUNT <= 1'h1;
        end else begin
            SHAPED_COUNT <= ~toggle_d;
        end
    end

endmodule : fdc_first_decade

`default_nettype wire

//--- fdc_first_decade_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_first_decade_checker (
    input wire logic                 CLOCK,
    input wire logic                 RSTN,
    input wire logic                 COUNT_EVENT,
    input wire logic                 COUNTER_UNIT_RESET_N,
    input wire fdc_pkg::fdc_out_t    DECADE_OUT,
    input wire fdc_pkg::fdc_level_t [4:0] RING_LEVEL,
    input wire logic                 SHAPED_COUNT,
    input wire logic                 RESET_PULSE,
    input wire logic                 CLEAR_PULSE
);
    import fdc_pkg::*;
    // ----
    // Helpers
    // ----
    logic [4:0] zeros;
    function automatic logic pz(input fdc_level_t x, input fdc_level_t y);
        return (x == FDC_LVL_PLUS && y == FDC_LVL_ZERO) ||
               (x == FDC_LVL_ZERO && y == FDC_LVL_PLUS);
    endfunction : pz
    always_comb begin
        for (int i = 0; i < 5; i++) zeros[i] = (RING_LEVEL[i] == FDC_LVL_ZERO);
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // ----
    // Properties
    // ----
    a_shaped_polarity: assert property (SHAPED_COUNT != DECADE_OUT.bcd[0])
        else $error("shaped count polarity");
    a_pair_encode: assert property (DECADE_OUT.pair == 5'h01 << DECADE_OUT.bcd[3:1])
        else $error("pair lines");
    a_carry_level: assert property (DECADE_OUT.carry == (DECADE_OUT.bcd > 4'h4))
        else $error("carry level");
    a_pair_ring: assert property (DECADE_OUT.pair == {
        pz(RING_LEVEL[2], RING_LEVEL[3]),
        pz(RING_LEVEL[0], RING_LEVEL[1]), pz(RING_LEVEL[3], RING_LEVEL[4]),
        pz(RING_LEVEL[1], RING_LEVEL[2]), pz(RING_LEVEL[4], RING_LEVEL[0])})
        else $error("pair vs ring");
    a_one_zero: assert property ($onehot(zeros))
        else $error("zero level count");
    a_count_step: assert property (COUNT_EVENT && !RESET_PULSE
        && !$fell(COUNTER_UNIT_RESET_N)
        |=> DECADE_OUT.bcd == (($past(DECADE_OUT.bcd) == 4'h9) ? 4'h0 : $past(DECADE_OUT.bcd) + 4'h1))
        else $error("count step");
    a_zero_advance: assert property (COUNT_EVENT && !RESET_PULSE
        && !$fell(COUNTER_UNIT_RESET_N)
        |=> zeros == {$past(zeros[3:0]), $past(zeros[4])})
        else $error("ring step");
    a_hold_idle: assert property (!COUNT_EVENT && !$fell(COUNTER_UNIT_RESET_N)
        |=> $stable(DECADE_OUT) && $stable(RING_LEVEL))
        else $error("count without event");
    a_unit_reset: assert property ($fell(COUNTER_UNIT_RESET_N)
        |=> RESET_PULSE && CLEAR_PULSE
        && DECADE_OUT == 10'h001 && RING_LEVEL == 10'h099)
        else $error("unit reset");
    a_pulse_single: assert property (RESET_PULSE
        |=> !RESET_PULSE && DECADE_OUT == 10'h001)
        else $error("pulse length");
    a_pulse_cause: assert property ($rose(RESET_PULSE) |-> !$past(COUNTER_UNIT_RESET_N)
        && $past(COUNTER_UNIT_RESET_N, 2) && CLEAR_PULSE)
        else $error("pulse cause");
    c_wrap: cover property (DECADE_OUT.bcd == 4'h9 && COUNT_EVENT ##1 DECADE_OUT.bcd == 4'h0);
    c_unit_reset: cover property ($fell(COUNTER_UNIT_RESET_N));
    c_back_to_back: cover property (COUNT_EVENT [*3]);
endmodule : fdc_first_decade_checker
bind fdc_first_decade fdc_first_decade_checker u_chk (.CLOCK, .RSTN, .COUNT_EVENT,
    .COUNTER_UNIT_RESET_N, .DECADE_OUT, .RING_LEVEL, .SHAPED_COUNT, .RESET_PULSE, .CLEAR_PULSE);
`default_nettype wire

//--- fdc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_partner (
    input  wire logic  clk,
    input  wire logic  unit_rst_n,
    input  wire logic  carry,
    output logic       pulse,
    output logic [7:0] tens
);
    // ----
    // Gated clock source and next decade
    // ----
    logic carry_q;
    initial begin
        pulse = 1'h0;
        tens = 8'h00;
        carry_q = 1'h0;
    end
    task automatic burst(input int n, input bit slow);
        repeat (n) begin
            @(negedge clk) pulse = 1'h1;
            if (slow) @(negedge clk) pulse = 1'h0;
        end
        @(negedge clk) pulse = 1'h0;
    endtask : burst
    always @(posedge clk) begin
        carry_q <= carry;
        if (!unit_rst_n) tens <= 8'h00;
        else if (carry_q && !carry) tens <= tens + 8'h01;
    end
endmodule : fdc_partner
`default_nettype wire

//--- fdc_first_decade_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_first_decade_tb;
    import fdc_pkg::*;
    logic             clock = 1'h0;
    logic             rstn = 1'h0;
    logic             unit_rst_n = 1'h1;
    wire logic        count_event;
    fdc_out_t         decade_out;
    fdc_level_t [4:0] ring_level;
    logic             shaped;
    logic             rst_pulse;
    logic             clr_pulse;
    logic [7:0]       tens;
    int               n_fail = 0;
    int               n_compared = 0;
    logic [9:0]       ring_tab [10] = '{10'h099, 10'h198, 10'h192, 10'h186, 10'h126,
                                        10'h066, 10'h264, 10'h261, 10'h249, 10'h219};
    wire logic [22:0] seen = {rst_pulse, clr_pulse, decade_out, ring_level, shaped};
    always #4 clock = ~clock;
    fdc_first_decade u_dut (.CLOCK(clock), .RSTN(rstn), .COUNT_EVENT(count_event),
        .COUNTER_UNIT_RESET_N(unit_rst_n), .DECADE_OUT(decade_out), .RING_LEVEL(ring_level),
        .SHAPED_COUNT(shaped), .RESET_PULSE(rst_pulse), .CLEAR_PULSE(clr_pulse));
    fdc_partner u_src (.clk(clock), .unit_rst_n(unit_rst_n), .carry(decade_out.carry),
        .pulse(count_event), .tens(tens));
    // ----
    // Checking
    // ----
    function automatic logic [22:0] e(input int n, input logic [1:0] p);
        return {p, n[3:0], n > 4, 5'h01 << (n / 2), ring_tab[n], ~n[0]};
    endfunction : e
    task automatic check(input logic [22:0] got, input logic [22:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // ----
    // Scenarios
    // ----
    task automatic t_walk;
        for (int k = 1; k <= 12; k++) begin
            u_src.burst(1, 1'b0);
            check(seen, e(k % 10, 2'h0));
        end
        check({15'h0000, tens}, 23'h000001);
        $display("walk done");
    endtask : t_walk
    task automatic t_burst;
        u_src.burst(25, 1'b0);
        check(seen, e(7, 2'h0));
        u_src.burst(6, 1'b1);
        check(seen, e(3, 2'h0));
        check({15'h0000, tens}, 23'h000004);
        $display("burst done");
    endtask : t_burst
    task automatic t_unit_reset;
        fork
            u_src.burst(3, 1'b0);
            begin
                @(negedge clock) unit_rst_n = 1'h0;
                @(posedge clock) #1 check(seen, e(0, 2'h3));
            end
        join
        check(seen, e(1, 2'h0));
        repeat (3) @(negedge clock);
        unit_rst_n = 1'h1;
        check(seen, e(1, 2'h0));
        $display("unit reset done");
    endtask : t_unit_reset
    task automatic t_async_reset;
        u_src.burst(4, 1'b0);
        @(negedge clock) rstn = 1'h0;
        @(negedge clock) check(seen, e(0, 2'h0));
        rstn = 1'h1;
        u_src.burst(1, 1'b0);
        check(seen, e(1, 2'h0));
        $display("async reset done");
    endtask : t_async_reset
    initial begin
        repeat (6) @(negedge clock);
        rstn = 1'h1;
        check(seen, e(0, 2'h0));
        t_walk;
        t_burst;
        t_unit_reset;
        t_async_reset;
        end_of_test;
    end
    initial begin
        #20000;
        n_fail++;
        end_of_test;
    end
endmodule : fdc_first_decade_tb
`default_nettype wire
